// >>> shared/pmsm_pkg.sv
// pmsm_pkg: constants for the phy management serial master
// assumes a 25 MHz core clock and a 32-bit AXI4-Lite register port
package pmsm_pkg;
  // register byte offsets
  localparam logic [7:0] PMSM_CTRL_OFF = 8'h00;
  localparam logic [7:0] PMSM_DATA_OFF = 8'h04;
  // control register field positions
  localparam int PMSM_BUSY_BIT  = 0;
  localparam int PMSM_WRSEL_BIT = 1;
  localparam int PMSM_CR_LSB    = 2;
  localparam int PMSM_REG_LSB   = 6;
  localparam int PMSM_PHY_LSB   = 11;
  // reset values
  localparam logic [31:0] PMSM_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PMSM_DATA_RST = 16'h0000;
  // frame layout, counted in mdc periods
  localparam int          PMSM_PRE_BITS   = 32;
  localparam int          PMSM_FRAME_BITS = 64;
  localparam logic [6:0]  PMSM_TA1_IDX    = 7'd46;
  localparam logic [6:0]  PMSM_DATA_IDX   = 7'd48;
  localparam logic [6:0]  PMSM_LAST_IDX   = 7'd63;
  localparam logic [1:0]  PMSM_START      = 2'b01;
  localparam logic [1:0]  PMSM_OP_RD      = 2'b10;
  localparam logic [1:0]  PMSM_OP_WR      = 2'b01;
  localparam logic [1:0]  PMSM_TA_WR      = 2'b10;
  // core clock divisors selected by the clock range field
  localparam logic [6:0]  PMSM_DIV_0 = 7'd42;
  localparam logic [6:0]  PMSM_DIV_1 = 7'd62;
  localparam logic [6:0]  PMSM_DIV_2 = 7'd16;
  localparam logic [6:0]  PMSM_DIV_3 = 7'd26;
  localparam logic [6:0]  PMSM_DIV_4 = 7'd102;
  localparam logic [6:0]  PMSM_DIV_5 = 7'd124;
  // axi response codes
  localparam logic [1:0]  PMSM_RESP_OK  = 2'b00;
  localparam logic [1:0]  PMSM_RESP_ERR = 2'b10;
endpackage

// >>> core/pmsm_mdc_div.sv
// pmsm_mdc_div: divides the core clock into mdc edge enables
// assumes the divisor only changes while run is low
`timescale 1ns/100ps
module pmsm_mdc_div
  import pmsm_pkg::*;
(
  // clock and reset
  input  wire logic       core_clock,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [6:0] divisor,
  // edge enables
  output logic            fall_en,
  output logic            rise_en
);
  typedef struct packed {
    logic [6:0] cnt;
  } pmsm_div_st_t;

  pmsm_div_st_t st_q;
  pmsm_div_st_t st_d;
  logic   [6:0] half;
  logic   [6:0] last;

  assign half = {1'b0, divisor[6:1]};
  assign last = divisor - 7'd1;

  always_comb
  begin
    st_d = st_q;
    if (!run)
      st_d.cnt = '0;
    else if (st_q.cnt == last)
      st_d.cnt = '0;
    else
      st_d.cnt = st_q.cnt + 7'd1;
  end

  // fall at count zero opens each bit, rise half a period later
  assign fall_en = run && (st_q.cnt == 7'd0);
  assign rise_en = run && (st_q.cnt == half);

  always_ff @(posedge core_clock or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule // pmsm_mdc_div

// >>> core/pmsm_master.sv
// pmsm_master: two-wire phy management master with axi4-lite registers
// assumes mdio_i comes from a pad and is asynchronous to core_clock
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module pmsm_master
  import pmsm_pkg::*;
(
  // clock and reset
  input  wire logic        core_clock,
  input  wire logic        reset_n,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // management link
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);
  typedef enum logic [2:0] {
    PMSM_IDLE = 3'b001,
    PMSM_SHIFT = 3'b010,
    PMSM_DONE = 3'b100
  } pmsm_state_t;

  typedef struct packed {
    pmsm_state_t state;
    // control and data register fields
    logic        busy;
    logic        wr_sel;
    logic [3:0]  clk_range;
    logic [4:0]  reg_addr;
    logic [4:0]  phy_addr;
    logic [15:0] data;
    // frame shifter
    logic [6:0]  bit_idx;
    logic [63:0] frame;
    logic [15:0] rx_shift;
    logic [6:0]  divisor;
    logic        mdc;
    logic        mdio_o;
    logic        mdio_oe;
    // mdio synchroniser
    logic        mdio_s1;
    logic        mdio_s2;
    // axi slave
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pmsm_st_t;

  pmsm_st_t st_q;
  pmsm_st_t st_d;
  logic     fall_en;
  logic     rise_en;
  logic     run;

  // clock range decode; reserved codes fall back to the slowest divisor
  function automatic logic [6:0] range_div(input logic [3:0] cr);
    unique case (cr)
      4'h0:    range_div = PMSM_DIV_0;
      4'h1:    range_div = PMSM_DIV_1;
      4'h2:    range_div = PMSM_DIV_2;
      4'h3:    range_div = PMSM_DIV_3;
      4'h4:    range_div = PMSM_DIV_4;
      4'h5:    range_div = PMSM_DIV_5;
      default: range_div = PMSM_DIV_5;
    endcase
  endfunction

  function automatic logic [31:0] ctrl_word(input pmsm_st_t s);
    ctrl_word = '0;
    ctrl_word[PMSM_BUSY_BIT] = s.busy;
    ctrl_word[PMSM_WRSEL_BIT] = s.wr_sel;
    ctrl_word[PMSM_CR_LSB +: 4] = s.clk_range;
    ctrl_word[PMSM_REG_LSB +: 5] = s.reg_addr;
    ctrl_word[PMSM_PHY_LSB +: 5] = s.phy_addr;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  assign run = (st_q.state == PMSM_SHIFT);

  pmsm_mdc_div u_div (
    .core_clock (core_clock),
    .reset_n (reset_n),
    .run     (run),
    .divisor (st_q.divisor),
    .fall_en (fall_en),
    .rise_en (rise_en)
  );

  always_comb
  begin
    logic [31:0] cw;
    logic        do_wr;
    cw    = '0;
    do_wr = 1'b0;
    st_d  = st_q;

    // two-flop synchroniser for the pad input
    st_d.mdio_s1 = mdio_i;
    st_d.mdio_s2 = st_q.mdio_s1;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !st_q.aw_held)
    begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_held)
    begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
    begin
      do_wr         = 1'b1;
      st_d.aw_held  = 1'b0;
      st_d.w_held   = 1'b0;
      st_d.bvalid   = 1'b1;
      st_d.bresp    = PMSM_RESP_OK;
      if (st_q.aw_addr != PMSM_CTRL_OFF && st_q.aw_addr != PMSM_DATA_OFF)
        st_d.bresp = PMSM_RESP_ERR;
    end

    // register writes; ignored while busy so the frame stays consistent
    if (do_wr && !st_q.busy)
    begin
      if (st_q.aw_addr == PMSM_CTRL_OFF)
      begin
        cw = merge(ctrl_word(st_q), st_q.w_data, st_q.w_strb);
        st_d.wr_sel    = cw[PMSM_WRSEL_BIT];
        st_d.clk_range = cw[PMSM_CR_LSB +: 4];
        st_d.reg_addr  = cw[PMSM_REG_LSB +: 5];
        st_d.phy_addr  = cw[PMSM_PHY_LSB +: 5];
        st_d.busy      = cw[PMSM_BUSY_BIT];
      end
      else if (st_q.aw_addr == PMSM_DATA_OFF)
      begin
        cw = merge({16'h0000, st_q.data}, st_q.w_data, st_q.w_strb);
        st_d.data = cw[15:0];
      end
    end

    // read channel
    if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
    if (s_axi_arvalid && !st_q.rvalid)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = PMSM_RESP_OK;
      if (s_axi_araddr == PMSM_CTRL_OFF)
        st_d.rdata = ctrl_word(st_q);
      else if (s_axi_araddr == PMSM_DATA_OFF)
        st_d.rdata = {16'h0000, st_q.data};
      else
      begin
        st_d.rdata = '0;
        st_d.rresp = PMSM_RESP_ERR;
      end
    end

    unique case (st_q.state)
      PMSM_IDLE:
      begin
        st_d.mdc     = 1'b0;
        st_d.mdio_oe = 1'b0;
        st_d.mdio_o  = 1'b1;
        if (st_q.busy)
        begin
          st_d.state   = PMSM_SHIFT;
          st_d.divisor = range_div(st_q.clk_range);
          st_d.bit_idx = '0;
          // whole frame built msb first
          st_d.frame = {{PMSM_PRE_BITS{1'b1}}, PMSM_START,
                        st_q.wr_sel ? PMSM_OP_WR : PMSM_OP_RD,
                        st_q.phy_addr, st_q.reg_addr,
                        PMSM_TA_WR,
                        st_q.wr_sel ? st_q.data : 16'hffff};
        end
      end
      PMSM_SHIFT:
      begin
        if (fall_en)
        begin
          st_d.mdc = 1'b0;
          // last bit keeps its full high phase; end the frame on the next fall
          if (st_q.bit_idx == 7'(PMSM_FRAME_BITS))
          begin
            st_d.mdio_oe = 1'b0;
            st_d.state   = PMSM_DONE;
          end
          else
          begin
            st_d.mdio_o = st_q.frame[PMSM_FRAME_BITS-1];
            // read frame releases from the turnaround onward
            st_d.mdio_oe = st_q.wr_sel || (st_q.bit_idx < PMSM_TA1_IDX);
          end
        end
        if (rise_en)
        begin
          st_d.mdc   = 1'b1;
          st_d.frame = {st_q.frame[PMSM_FRAME_BITS-2:0], 1'b0};
          if (!st_q.wr_sel && st_q.bit_idx >= PMSM_DATA_IDX)
            st_d.rx_shift = {st_q.rx_shift[14:0], st_q.mdio_s2};
          st_d.bit_idx = st_q.bit_idx + 7'd1;
        end
      end
      PMSM_DONE:
      begin
        // hold mdc high a moment is unneeded; go straight back to idle
        st_d.mdc     = 1'b0;
        st_d.mdio_oe = 1'b0;
        st_d.busy    = 1'b0;
        if (!st_q.wr_sel)
          st_d.data = st_q.rx_shift;
        st_d.state = PMSM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q        <= '0;
      st_q.state  <= PMSM_IDLE;
      st_q.mdio_o <= 1'b1;
      st_q.data   <= PMSM_DATA_RST;
      st_q.divisor <= PMSM_DIV_0;
    end
    else
      st_q <= st_d;
  end

  // handshake outputs
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready  = !st_q.w_held;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  // link outputs
  assign mdc     = st_q.mdc;
  assign mdio_o  = st_q.mdio_o;
  assign mdio_oe = st_q.mdio_oe;
endmodule // pmsm_master

// >>> sim/pmsm_phy_model.sv
// pmsm_phy_model: far-end phy management port with one register
// assumes mdc low when idle and a pull-up on the shared mdio wire
`timescale 1ns/100ps
module pmsm_phy_model
(
  // link
  input  wire logic        mdc,
  input  wire logic        reset_n,
  input  wire logic        mdio,
  // register contents and last frame seen
  input  wire logic [15:0] rd_val,
  output logic             phy_oe,
  output logic             phy_o,
  output logic [63:0]      frame_q
);
  logic [5:0] cnt_q;
  logic       rd_q;
  always @(posedge mdc or negedge reset_n)
    if (!reset_n)
    begin
      cnt_q   <= 6'h00;
      rd_q    <= 1'b0;
      frame_q <= 64'h0;
    end
    else
    begin
      cnt_q   <= cnt_q + 6'h01;
      frame_q <= {frame_q[62:0], mdio};
      if (cnt_q == 6'h24)
        rd_q  <= frame_q[1:0] == 2'b10;
    end
  // drive on the falling edge so bits are stable at the rise
  always @(negedge mdc or negedge reset_n)
    if (!reset_n)
    begin
      phy_oe <= 1'b0;
      phy_o  <= 1'b1;
    end
    else
    begin
      phy_oe <= rd_q && cnt_q >= 6'h2f;
      phy_o  <= cnt_q == 6'h2f ? 1'b0 : rd_val[4'(6'h3f - cnt_q)];
    end
endmodule // pmsm_phy_model

// >>> sim/pmsm_master_properties.sv
// pmsm_master_properties: port checks on the management master
// assumes one clock domain; bound into every pmsm_master
`timescale 1ns/100ps
module pmsm_master_props
  import pmsm_pkg::*;
(
  // clock and reset
  input wire logic        core_clock,
  input wire logic        reset_n,
  // register bus
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // link
  input wire logic        mdc,
  input wire logic        mdio_o,
  input wire logic        mdio_oe
);
  default clocking cb @(posedge core_clock); endclocking
  default disable iff (!reset_n);
  // cycles since mdc last moved, saturating
  logic       mdc_q;
  logic [7:0] still_q;
  always_ff @(posedge core_clock or negedge reset_n)
    if (!reset_n)
    begin
      mdc_q   <= 1'b0;
      still_q <= 8'h00;
    end
    else
    begin
      mdc_q   <= mdc;
      still_q <= (mdc != mdc_q) ? 8'h00 : still_q + 8'(still_q != 8'hff);
    end
  a_idle_released: assert property (still_q > 8'd250 |-> !mdc && !$past(mdio_oe, 100))
    else $error("link idle but mdio still driven");
  a_mdc_high_min: assert property ($rose(mdc) |=> mdc [*7])
    else $error("mdc high phase too short");
  a_mdc_low_min: assert property ($fell(mdc) |=> !mdc [*7])
    else $error("mdc low phase too short");
  a_bit_on_fall: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_o) |-> !mdc)
    else $error("mdio moved while mdc high");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:3] != 5'h0
    |=> s_axi_rvalid && s_axi_rresp == PMSM_RESP_ERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_data_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == PMSM_DATA_OFF
    |=> s_axi_rvalid && s_axi_rresp == PMSM_RESP_OK && s_axi_rdata[31:16] == 16'h0)
    else $error("data read answered wrongly");
endmodule // pmsm_master_props
bind pmsm_master pmsm_master_props pmsm_master_props_i (.core_clock, .reset_n, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mdc, .mdio_o, .mdio_oe);

// >>> sim/tb.sv
// tb: management master driven over axi4-lite against the phy model
// assumes a 25 MHz core clock; frames are judged as the phy saw them
`timescale 1ns/100ps
module tb
  import pmsm_pkg::*;
;
  typedef struct {
    logic [4:0]  phy;
    logic [4:0]  rg;
    logic [3:0]  cr;
    logic        wr;
    logic [15:0] dat;
  } pmsm_row_t;
  // one row per clock range, edge addresses, reads and writes mixed
  pmsm_row_t   rows [6] = '{'{5'h00, 5'h1f, 4'h0, 1'b1, 16'ha5c3},
    '{5'h1f, 5'h00, 4'h1, 1'b0, 16'h8001}, '{5'h15, 5'h0a, 4'h2, 1'b1, 16'h0ff0},
    '{5'h0a, 5'h15, 4'h3, 1'b0, 16'h5aa5}, '{5'h01, 5'h10, 4'h4, 1'b0, 16'hc33c},
    '{5'h10, 5'h01, 4'h5, 1'b1, 16'h7ffe}};
  int          divs [6] = '{42, 62, 16, 26, 102, 124};
  logic        core_clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, mdc, mdio_o, mdio_oe, phy_oe, phy_o, mdc_d;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] rd_val;
  logic [63:0] frame;
  int          err_count, n_compared, cyc, last_rise, per;
  // pull-up when released; both driving shows as unknown
  wire         mdio_w = mdio_oe ? (phy_oe ? 1'bx : mdio_o) : (phy_oe ? phy_o : 1'b1);
  pmsm_master pmsm_master_i (.core_clock, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe);
  pmsm_phy_model pmsm_phy_model_i (.mdc, .reset_n, .mdio(mdio_w), .rd_val, .phy_oe, .phy_o,
    .frame_q(frame));
  always #20 core_clock = ~core_clock;
  // mdc period in core cycles, last one kept
  always @(posedge core_clock)
  begin
    cyc++;
    mdc_d <= mdc;
    if (mdc && !mdc_d)
    begin
      per       = cyc - last_rise;
      last_rise = cyc;
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_r, w_r, b_r;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // ready sampled mid-cycle: it is what the slave sees at the next rise
    do
    begin
      @(negedge core_clock);
      aw_r = s_axi_awready;
      w_r  = s_axi_wready;
      b_r  = s_axi_bvalid;
      r    = s_axi_bresp;
      @(posedge core_clock);
      if (aw_r)
        s_axi_awvalid <= 1'b0;
      if (w_r)
        s_axi_wvalid <= 1'b0;
    end
    while (!b_r);
    s_axi_bready <= 1'b0;
    @(posedge core_clock);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_r, rv_r;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(negedge core_clock);
      ar_r = s_axi_arready;
      rv_r = s_axi_rvalid;
      d    = s_axi_rdata;
      r    = s_axi_rresp;
      @(posedge core_clock);
      if (ar_r)
        s_axi_arvalid <= 1'b0;
    end
    while (!rv_r);
    s_axi_rready <= 1'b0;
    @(posedge core_clock);
  endtask
  initial
  begin
    logic [31:0] d, c;
    logic [1:0]  r;
    core_clock = 1'b0;
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_val} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge core_clock);
    reset_n <= 1'b1;
    @(posedge core_clock);
    foreach (rows[i])
    begin
      rd_val = rows[i].dat;
      c = {16'h0, rows[i].phy, rows[i].rg, rows[i].cr, rows[i].wr, 1'b1};
      if (rows[i].wr)
        axi_wr(PMSM_DATA_OFF, {16'h0, rows[i].dat}, r);
      axi_wr(PMSM_CTRL_OFF, c, r);
      chk(r, PMSM_RESP_OK);
      do
        axi_rd(PMSM_CTRL_OFF, d, r);
      while (d[0] !== 1'b0);
      chk(d, c & 32'hffff_fffe);
      chk(frame, {32'hffff_ffff, 2'b01, rows[i].wr ? 2'b01 : 2'b10, rows[i].phy, rows[i].rg,
        2'b10, rows[i].dat});
      chk(64'(per), 64'(divs[rows[i].cr]));
      chk({mdc, mdio_oe}, 2'b00);
      axi_rd(PMSM_DATA_OFF, d, r);
      chk(d, {16'h0, rows[i].dat});
    end
    axi_rd(8'h08, d, r);
    chk({r, d}, {PMSM_RESP_ERR, 32'h0});
    axi_wr(8'h0c, 32'h1, r);
    chk(r, PMSM_RESP_ERR);
    // clearing busy mid-frame is ignored, then reset cuts the frame
    axi_wr(PMSM_CTRL_OFF, 32'h0000_0a0b, r);
    axi_wr(PMSM_CTRL_OFF, 32'h0, r);
    axi_rd(PMSM_CTRL_OFF, d, r);
    chk(d, 32'h0000_0a0b);
    repeat (300) @(posedge core_clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clock);
    chk({mdc, mdio_oe}, 2'b00);
    reset_n <= 1'b1;
    @(posedge core_clock);
    axi_rd(PMSM_CTRL_OFF, d, r);
    chk(d, PMSM_CTRL_RST);
    axi_rd(PMSM_DATA_OFF, d, r);
    chk(d, 32'h0);
    wrap_up;
  end
  initial
  begin
    repeat (60000) @(posedge core_clock);
    err_count++;
    wrap_up;
  end
endmodule // tb
